// file: logic/lcd_power_save_control.sv
// power save sequencer: blanks the panel, stops clocks, parks pins
`timescale 1ns/1ps
`include "lcd_power_save_defines.svh"
module lcd_power_save_control (
    input  wire logic                             i_sys_clk,
    input  wire logic                             i_resetn,
    input  wire logic                             i_indirect_mode,
    input  wire logic                             i_enable_wr,
    input  wire logic [7:0]                       i_enable_wdata,
    input  wire logic                             i_cmd_valid,
    input  wire logic [7:0]                       i_cmd_code,
    input  wire logic                             i_display_on,
    input  wire logic                             i_frame_start,
    input  wire lcd_power_save_pkg::panel_pins_t  i_scan_pins,
    input  wire lcd_power_save_pkg::host_pins_t   i_host_drive,
    input  wire logic [7:0]                       i_mem_ctrl,
    output logic                                  o_save_enable,
    output logic                                  o_asleep,
    output logic                                  o_clk_run,
    output logic [7:0]                            o_mem_ctrl,
    output lcd_power_save_pkg::panel_pins_t       o_panel,
    output lcd_power_save_pkg::host_pins_t        o_host
);
    import lcd_power_save_pkg::*;

    localparam logic [7:0]  CMD_POWER_SAVE = 8'h53;
    localparam logic [7:0]  CMD_SYS_CONFIG = 8'h40;
    localparam logic [19:0] FRAME_LAST     = 20'(`PS_FRAME_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    logic [1:0] rst_sync_q;
    logic       rst_n;
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // decode used by both the power save and sys config command paths
    function automatic logic is_cmd(input logic v, input logic [7:0] c, input logic [7:0] k);
        return v && (c == k);
    endfunction

    // fixed parked levels of panel pins
    function automatic panel_pins_t parked_pins();
        panel_pins_t p;
        p = '0;
        p.row_shift_clock      = 1'b1;
        p.column_driver_select = 1'b1;
        return p;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // enable bit, set or cleared by register write or command
    logic en_q;
    logic en_d;
    logic go_sleep;
    logic go_wake;
    logic [7:0] mem_q;
    assign go_sleep = (!i_indirect_mode && i_enable_wr && i_enable_wdata[`PS_ENABLE_BIT])
                   || (i_indirect_mode && is_cmd(i_cmd_valid, i_cmd_code, CMD_POWER_SAVE));
    assign go_wake  = (!i_indirect_mode && i_enable_wr && !i_enable_wdata[`PS_ENABLE_BIT])
                   || (i_indirect_mode && is_cmd(i_cmd_valid, i_cmd_code, CMD_SYS_CONFIG));
    always_comb begin
        en_d = en_q;
        if (go_wake) begin
            en_d = 1'b0;
        end
        if (go_sleep) begin
            en_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state record
    ps_regs_t r_q;
    ps_regs_t r_d;
    logic     frame_tick;
    assign frame_tick = (r_q.frame_cnt == FRAME_LAST);

    always_comb begin
        r_d = r_q;
        // frame counter runs only while clocks run; stopping it models the halt
        if (r_q.clk_run) begin
            r_d.frame_cnt = frame_tick ? 20'h0 : r_q.frame_cnt + 20'h1;
        end
        unique case (r_q.state)
            ST_RUN: begin
                if (en_q) begin
                    r_d.state        = ST_BLANK;
                    r_d.frame_cnt    = 20'h0;
                    r_d.blank_frames = 2'h0;
                end
            end
            ST_BLANK: begin
                if (!en_q) begin
                    r_d.state = ST_WAKE;
                end else if (frame_tick) begin
                    // one full blank frame then drop disable; sleep after second
                    r_d.blank_frames = r_q.blank_frames + 2'h1;
                    if (r_q.blank_frames == 2'h1) begin
                        r_d.state   = ST_SLEEP;
                        r_d.clk_run = 1'b0;
                    end
                end
            end
            ST_SLEEP: begin
                if (!en_q) begin
                    r_d.state     = ST_WAKE;
                    r_d.clk_run   = 1'b1;
                    r_d.frame_cnt = 20'h0;
                end
            end
            ST_WAKE: begin
                // wait for panel scan to begin a new frame
                if (i_frame_start) begin
                    r_d.state        = ST_RUN;
                    r_d.blank_frames = 2'h0;
                end
            end
            default: r_d.state = ST_RUN;
        endcase
        // pin drive
        if (r_d.state == ST_RUN && i_display_on) begin
            r_d.panel = i_scan_pins;
            r_d.host  = i_host_drive;
            r_d.panel.row_driver_disable = 1'b1;
        end else begin
            r_d.panel = parked_pins();
            r_d.host.data_oe_n = 1'b1;
            r_d.host.wait_oe_n = 1'b1;
            // disable stays high through first blank frame
            r_d.panel.row_driver_disable =
                (r_d.state == ST_BLANK && r_d.blank_frames == 2'h0) ||
                (r_d.state == ST_RUN);
            if (r_d.state == ST_RUN) begin
                r_d.panel.row_driver_disable = 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q  <= 1'b0;
            mem_q <= 8'h00;
            // parked panel levels and a floating bus from reset on
            r_q   <= '{state: ST_RUN, frame_cnt: 20'h0, blank_frames: 2'h0, clk_run: 1'b1,
                       panel: panel_pins_t'(12'h402), host: host_pins_t'(11'h003)};
        end else begin
            en_q <= en_d;
            r_q  <= r_d;
            if (r_q.state != ST_SLEEP) begin
                mem_q <= i_mem_ctrl;
            end
        end
    end

    assign o_save_enable = en_q;
    assign o_asleep      = (r_q.state == ST_SLEEP);
    assign o_clk_run     = r_q.clk_run;
    assign o_mem_ctrl    = mem_q;
    assign o_panel       = r_q.panel;
    assign o_host        = r_q.host;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence enter_req_s;
        $rose(en_q) && r_q.state == ST_RUN;
    endsequence
    sequence blank_frame_s;
        r_q.state == ST_BLANK;
    endsequence

    no_early_sleep_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        $rose(r_q.state == ST_SLEEP) |-> $past(frame_tick))
        else $error("sleep entered without a completed blank frame");
    blank_after_en_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        enter_req_s |=> blank_frame_s)
        else $error("blanking did not start after enable");
    mem_hold_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (o_asleep && $past(o_asleep)) |-> $stable(o_mem_ctrl))
        else $error("memory control moved while asleep");
    wake_on_clear_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (o_asleep && !en_q) |=> r_q.state == ST_WAKE)
        else $error("did not wake after enable cleared");
    clk_stop_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        o_asleep |-> !o_clk_run)
        else $error("clocks running while asleep");
    bus_float_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (r_q.state != ST_RUN) |-> (o_host.data_oe_n && o_host.wait_oe_n))
        else $error("host bus driven during power save");
    park_levels_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        o_asleep |-> (o_panel.row_shift_clock && o_panel.column_driver_select
                      && o_panel.panel_data_out == 4'h0 && !o_panel.frame_pulse))
        else $error("panel pins not parked");
    disable_low_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        o_asleep |-> !o_panel.row_driver_disable)
        else $error("row driver disable high while asleep");
    // disable must not come back before the scan has restarted a frame
    wake_dis_low_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (r_q.state == ST_WAKE) |-> !o_panel.row_driver_disable)
        else $error("row driver disable raised before frame restart");
    dis_fall_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        ($fell(o_panel.row_driver_disable) && r_q.state == ST_BLANK) |-> r_q.blank_frames == 2'h1)
        else $error("row driver disable fell outside the frame window");
endmodule

// file: logic/lcd_power_save_defines.svh
// timing constants and enable bit position for the lcd power save sequencer
`ifndef LCD_POWER_SAVE_DEFINES_SVH
`define LCD_POWER_SAVE_DEFINES_SVH
`define PS_CLK_PERIOD_NS   10
`define PS_FRAME_TIME_NS   100000
`define PS_FRAME_CYCLES    (`PS_FRAME_TIME_NS / `PS_CLK_PERIOD_NS)
`define PS_FRAME_CNT_W     20
`define PS_ENABLE_BIT      0
`define PS_WAKE_SETTLE_NS  10
`define PS_WAKE_CYCLES     ((`PS_WAKE_SETTLE_NS + `PS_CLK_PERIOD_NS - 1) / `PS_CLK_PERIOD_NS)
`endif

// file: logic/lcd_power_save_pkg.sv
// types for the lcd power save sequencer
package lcd_power_save_pkg;
    typedef enum logic [2:0] {
        ST_RUN,
        ST_BLANK,
        ST_SLEEP,
        ST_WAKE
    } ps_state_t;

    typedef struct packed {
        logic       frame_pulse;
        logic       row_shift_clock;
        logic       ac_drive_toggle;
        logic       line_pulse;
        logic       column_enable_chain_clock;
        logic       pixel_shift_clock;
        logic [3:0] panel_data_out;
        logic       column_driver_select;
        logic       row_driver_disable;
    } panel_pins_t;

    typedef struct packed {
        logic [7:0] data;
        logic       wait_n;
        logic       data_oe_n;
        logic       wait_oe_n;
    } host_pins_t;

    typedef struct packed {
        ps_state_t   state;
        logic [19:0] frame_cnt;
        logic [1:0]  blank_frames;
        logic        clk_run;
        panel_pins_t panel;
        host_pins_t  host;
    } ps_regs_t;
endpackage

// file: verif/scan_host_model.sv
// scanner and host-side drive model facing the power save sequencer
`timescale 1ns/1ps
module scan_host_model
    import lcd_power_save_pkg::*;
#(parameter int FRAME = 10000) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_clk_run,
    input  wire logic [31:0] i_rnd,
    output logic             o_frame_start,
    output panel_pins_t      o_scan_pins,
    output host_pins_t       o_host_drive,
    output logic [7:0]       o_mem_ctrl
);
    int cnt = 0;
    initial o_frame_start = 1'b0;
    // frames only while clocks run; a halted scanner produces no frame pulse
    always @(posedge i_sys_clk) begin
        cnt <= #1 (!i_clk_run || cnt == FRAME - 1) ? 0 : cnt + 1;
        o_frame_start <= #1 i_clk_run && cnt == FRAME - 1;
    end
    // busy levels change every cycle so a stuck or parked output shows up
    assign o_scan_pins  = panel_pins_t'({i_rnd[11:1], 1'b1});
    assign o_host_drive = host_pins_t'({i_rnd[19:12], i_rnd[20], 2'b00});
    assign o_mem_ctrl   = i_rnd[31:24];
endmodule

// file: verif/test_lcd_power_save_control.sv
// self-checking bench for the lcd power save sequencer
`timescale 1ns/1ps
module test_lcd_power_save_control;
    import lcd_power_save_pkg::*;
    localparam int FRAME = 10000;
    localparam panel_pins_t PARK = panel_pins_t'(12'h402);
    logic        i_sys_clk, i_resetn, i_indirect_mode, i_enable_wr;
    logic        i_cmd_valid, i_display_on, fs, clk_run, save_en, asleep;
    logic [7:0]  i_enable_wdata, i_cmd_code, mem_in, mem_out;
    logic [31:0] rnd = 32'h0000_0011;
    logic [1:0]  seen = 2'b00;
    logic [1:0]  notes[$];
    panel_pins_t scan, panel;
    host_pins_t  hdrv, host;
    int          err_total = 0;
    int          n_checks = 0;
    lcd_power_save_control lcd_power_save_control_inst (.i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn), .i_indirect_mode(i_indirect_mode), .i_enable_wr(i_enable_wr),
        .i_enable_wdata(i_enable_wdata), .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code),
        .i_display_on(i_display_on), .i_frame_start(fs), .i_scan_pins(scan),
        .i_host_drive(hdrv), .i_mem_ctrl(mem_in), .o_save_enable(save_en), .o_asleep(asleep),
        .o_clk_run(clk_run), .o_mem_ctrl(mem_out), .o_panel(panel), .o_host(host));
    scan_host_model scan_host_model_inst (.i_sys_clk(i_sys_clk), .i_clk_run(clk_run),
        .i_rnd(rnd), .o_frame_start(fs), .o_scan_pins(scan), .o_host_drive(hdrv),
        .o_mem_ctrl(mem_in));
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    always @(posedge i_sys_clk) rnd <= #1 xs(rnd);
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // each change of the sleep/disable pair retires the oldest note
    always @(negedge i_sys_clk) begin
        if (i_resetn && {asleep, panel.row_driver_disable} !== seen) begin
            seen = {asleep, panel.row_driver_disable};
            check("sleep/disable pair", notes.size() ? notes.pop_front() : 2'b11, seen);
        end
    end
    // bounded wait on disable (0), sleep (1) or clock run (2)
    task automatic wait_bit(input int w, input logic lvl, input int lim, output int n);
        logic v;
        n = 0;
        v = ~lvl;
        while (v !== lvl && n <= lim) begin
            @(negedge i_sys_clk);
            n++;
            v = (w == 0) ? panel.row_driver_disable : (w == 1) ? asleep : clk_run;
        end
        if (v !== lvl) begin
            check("wait on output", lvl, v);
            give_verdict();
        end
    endtask
    // one strobe cycle, changed just after the edge
    task automatic request(input logic ind, input logic [7:0] wd, input logic [7:0] cc);
        @(posedge i_sys_clk);
        #1;
        i_cmd_valid = ind;
        i_cmd_code = cc;
        i_enable_wr = !ind;
        i_enable_wdata = wd;
        @(posedge i_sys_clk);
        #1;
        i_cmd_valid = 1'b0;
        i_enable_wr = 1'b0;
    endtask
    // while running, outputs follow the scanner one edge later
    task automatic check_follow();
        panel_pins_t sp;
        host_pins_t  hd;
        logic [7:0]  mc;
        @(negedge i_sys_clk);
        sp = scan;
        hd = hdrv;
        mc = mem_in;
        sp.row_driver_disable = 1'b1;
        @(negedge i_sys_clk);
        check("panel follows scan", sp, panel);
        check("host bus driven", hd, host);
        check("memory control follows", mc, mem_out);
    endtask
    task automatic cycle_mode(input logic ind);
        int n, m;
        logic [7:0] held;
        @(posedge i_sys_clk);
        #1;
        i_indirect_mode = ind;
        notes.push_back(2'b00);
        notes.push_back(2'b10);
        notes.push_back(2'b00);
        notes.push_back(2'b01);
        // drive supplies assumed already off before the command
        request(ind, 8'h01, 8'h53);
        wait_bit(0, 1'b0, 2 * FRAME + 4, n);
        check("disable fall in window", 1, n >= FRAME + 1 && n <= 2 * FRAME + 1);
        wait_bit(1, 1'b1, 2 * FRAME, m);
        check("sleep after blank frame", 1, n + m >= FRAME && n + m <= 2 * FRAME + 4);
        check("parked panel", PARK, panel);
        check("bus floats", 2'b11, {host.data_oe_n, host.wait_oe_n});
        check("clocks stopped", 1'b0, clk_run);
        held = mem_out;
        repeat (40) @(negedge i_sys_clk);
        check("memory control held", held, mem_out);
        check("enable retained", 1'b1, save_en);
        request(ind, 8'h00, 8'h40);
        wait_bit(2, 1'b1, 10, n);
        wait_bit(0, 1'b1, FRAME + 10, n);
        check_follow();
        request(ind, 8'h00, 8'h00);
        if (ind) request(ind, 8'h00, 8'h00);
        repeat (20) @(negedge i_sys_clk);
        check("awake after dummy writes", 1'b0, asleep);
        $display("mode %0d sequence done", ind);
    endtask
    initial begin
        i_resetn = 1'b0;
        i_indirect_mode = 1'b0;
        i_enable_wr = 1'b0;
        i_cmd_valid = 1'b0;
        i_display_on = 1'b1;
        i_enable_wdata = 8'h00;
        i_cmd_code = 8'h00;
        notes.push_back(2'b01);
        repeat (16) @(posedge i_sys_clk);
        #1 i_resetn = 1'b1;
        repeat (5) @(posedge i_sys_clk);
        for (int k = 0; k < 2; k++) cycle_mode(k[0]);
        notes.push_back(2'b00);
        notes.push_back(2'b01);
        @(posedge i_sys_clk);
        #1;
        i_display_on = 1'b0;
        repeat (4) @(negedge i_sys_clk);
        check("display off panel", PARK, panel);
        check("display off bus", 2'b11, {host.data_oe_n, host.wait_oe_n});
        @(posedge i_sys_clk);
        #1;
        i_display_on = 1'b1;
        repeat (6) @(negedge i_sys_clk);
        check("notes left", 0, notes.size());
        $display("display off test done");
        give_verdict();
    end
endmodule
